/* rtl/edge_divider.sv */
// Integer edge divider: one output pulse for every programmed number of input ticks.
`timescale 1ns/1ps
module edge_divider #(
    parameter int WIDTH = 19
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             resetn,
    // Input ticks and ratio.
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] ratio,
    // Divided output.
    output logic                  pulse_q
);
    logic [WIDTH-1:0] count_q;

    // A ratio of zero behaves as one so the divider never stalls.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end
        else
        begin
            pulse_q <= 1'b0;
            if (tick)
            begin
                if (count_q + WIDTH'(1) >= ratio)
                begin
                    count_q <= '0;
                    pulse_q <= 1'b1;
                end
                else
                begin
                    count_q <= count_q + WIDTH'(1);
                end
            end
        end
    end

    a_div_count_bound : assert property (@(posedge clk) disable iff (!resetn)
        (ratio != '0) |-> ##1 (count_q < ratio || $changed(ratio)))
        else $error("divider count passed its ratio");
endmodule

/* rtl/ld_window_timer.sv */
// Digital lock window timer driven by an internal lock-detect clock enable.
`timescale 1ns/1ps
module ld_window_timer (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Tracker side.
    win_timer_if.timer win
);
    logic [1:0] presc_q;
    logic [7:0] halves_q;
    logic       run_q;
    logic       half_tick;

    // One half period of the lock-detect clock lasts speed+1 cycles, slowest at code 3.
    assign half_tick = (presc_q == win.speed_code);

    // Prescaler restarts with each window so the window length is exact.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            presc_q    <= 2'h0;
            win.ld_clk <= 1'b0;
        end
        else if (win.start)
        begin
            presc_q <= 2'h0;
        end
        else if (half_tick)
        begin
            presc_q    <= 2'h0;
            win.ld_clk <= ~win.ld_clk;
        end
        else
        begin
            presc_q <= presc_q + 2'h1;
        end
    end

    // Window lasts 2^code half periods: code 0 is half a clock, code 7 is 64 clocks.
    always_ff @(posedge clk)
    begin
        win.expired <= 1'b0;
        if (!resetn)
        begin
            halves_q <= 8'h00;
            run_q    <= 1'b0;
        end
        else if (win.start)
        begin
            halves_q <= 8'h00;
            run_q    <= 1'b1;
        end
        else if (run_q && half_tick)
        begin
            halves_q <= halves_q + 8'h01;
            if (halves_q + 8'h01 == (8'h01 << win.div_code))
            begin
                run_q       <= 1'b0;
                win.expired <= 1'b1;
            end
        end
    end

    a_timer_expiry : assert property (@(posedge clk) disable iff (!resetn)
        win.expired |-> $past(run_q) && !run_q)
        else $error("window expired while the timer was idle");
endmodule

/* rtl/pll_ctrl_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the loop control block.
`ifndef PLL_CTRL_CFG_SVH
`define PLL_CTRL_CFG_SVH

// Register indices, as the host addresses them.
`define REG_REF_DIV        8'h02
`define REG_FB_INT         8'h03
`define REG_FB_FRAC        8'h04
`define REG_MODE           8'h06
`define REG_LOCK_CFG       8'h07
`define REG_DETECTOR       8'h0B
`define REG_PIN_CTRL       8'h0F
`define REG_STATUS         8'h12

// Reset values.
`define RST_REF_DIV        14'h0001
`define RST_FB_INT         19'h00014
`define RST_FB_FRAC        24'h000000
`define RST_MODE           24'h000000
`define RST_LOCK_CFG       12'h000
`define RST_DETECTOR       11'h060
`define RST_PIN_CTRL       7'h01

// Field positions.
`define MODE_FRAC_BIT      11
`define LCFG_COUNT_LSB     0
`define LCFG_ENABLE_BIT    3
`define LCFG_WINSEL_BIT    6
`define LCFG_DIV_LSB       7
`define LCFG_SPEED_LSB     10
`define DET_UP_EN_BIT      5
`define DET_DN_EN_BIT      6
`define DET_FORCE_UP_BIT   9
`define DET_FORCE_DN_BIT   10
`define PIN_SEL_LSB        0
`define PIN_SERIAL_BIT     6
`define STAT_LOCK_BIT      1
`define PIN_SEL_LOCK       5'h01

// Divider ranges.
`define FB_INT_MIN         19'h00010
`define FB_INT_MAX         19'h7FFFF
`define FB_FRAC_MIN        19'h00014
`define FB_FRAC_MAX        19'h7FFFB

// Timing: fixed window in ns, clock period in ps, window in cycles rounded up.
`define ANALOG_WIN_NS      10
`define CLK_PERIOD_PS      8000
`define ANALOG_WIN_CYC     ((`ANALOG_WIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* rtl/pll_ctrl_pkg.sv */
// Types shared by the loop control block.
package pll_ctrl_pkg;

    // Lock window tracker states.
    typedef enum logic [2:0]
    {
        LD_IDLE = 3'b001,
        LD_OPEN = 3'b010,
        LD_LATE = 3'b100
    } ld_state_type;

endpackage

/* rtl/pll_loop_ctrl.sv */
// Loop control: reference and feedback dividers, phase detector control and window lock detect.
// Notes on behaviour
// - Reference divider divides by 1 to 16383.
// - Fractional feedback averages 20 to 524283.
// - Integer feedback divides by 16 to 524287.
// - Up enable low masks up pumping.
// - Down enable low masks down pumping.
// - Both enables low floats pump unless a force bit is set, rest runs.
// - Force bits hold pump up or down.
// - Lock enable gates all lock detection.
// - Only the edge time difference matters.
// - Window opens on whichever edge comes first.
// - Window select low gives fixed 10 ns window; here two 8 ns cycles, 16 ns.
// - Digital window counts lock-detect clock cycles.
// - Divide codes map 0.5 up to 64.
// - Speed code 0 fastest, 3 slowest.
// - Lock after programmed consecutive in-window arrivals.
// - One late arrival clears lock at once.
// - Status bit one reads the lock flag.
// - Pin select one puts lock on pin.
// - Serial reads borrow the pin temporarily.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pll_ctrl_cfg.svh"
module pll_loop_ctrl (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [23:0] reg_rdata_q,
    // Reference and VCO inputs from pins.
    input  wire logic        ref_in,
    input  wire logic        vco_in,
    // Serial port read in progress and its data bit.
    input  wire logic        serial_read_active,
    input  wire logic        serial_read_data,
    // Charge pump drive.
    output logic             pump_up_q,
    output logic             pump_down_q,
    output logic             pump_drive_en_q,
    // Pins.
    output logic             lock_or_serial_out_pin,
    output logic             general_test_output,
    output logic             lock_q
);
    logic [13:0] ref_div_q;
    logic [18:0] fb_int_q;
    logic [23:0] fb_frac_q;
    logic [23:0] mode_q;
    logic [11:0] lock_cfg_q;
    logic [10:0] detector_q;
    logic [6:0]  pin_ctrl_q;
    logic [2:0]  ref_sync_q;
    logic [2:0]  vco_sync_q;
    logic        ref_lvl_q;
    logic        vco_lvl_q;
    logic        ref_tick;
    logic        vco_tick;
    logic [23:0] frac_acc_q;
    logic        frac_carry_q;
    logic [18:0] fb_ratio;
    logic        ref_pulse;
    logic        fb_pulse;
    logic        pfd_up_q;
    logic        pfd_dn_q;
    logic        ld_enable;
    logic        win_digital;
    logic        detector_up_enable;
    logic        detector_down_enable;
    logic        pump_force_up;
    logic        pump_force_down;
    pll_ctrl_pkg::ld_state_type ld_state_q;
    logic        first_ref_q;
    logic [3:0]  analog_cnt_q;
    logic        analog_expired;
    logic        win_expired;
    logic        partner;
    logic        pair_in;
    logic        pair_out;
    logic [11:0] win_count_q;
    logic [11:0] count_target;
    win_timer_if win ();

    // Clamp the feedback ratio to the range of the selected mode.
    function automatic logic [18:0] clamp_ratio(input logic [19:0] raw, input logic frac);
        logic [19:0] lo;
        logic [19:0] hi;
        lo = frac ? {1'b0, `FB_FRAC_MIN} : {1'b0, `FB_INT_MIN};
        hi = frac ? {1'b0, `FB_FRAC_MAX} : {1'b0, `FB_INT_MAX};
        if (raw < lo)
            return lo[18:0];
        else if (raw > hi)
            return hi[18:0];
        else
            return raw[18:0];
    endfunction

    // In-window arrivals needed for lock: 16 at code 0 doubling to 2048 at code 7.
    function automatic logic [11:0] lock_count(input logic [2:0] code);
        return 12'h010 << code;
    endfunction

    assign ld_enable            = lock_cfg_q[`LCFG_ENABLE_BIT];
    assign win_digital          = lock_cfg_q[`LCFG_WINSEL_BIT];
    assign detector_up_enable   = detector_q[`DET_UP_EN_BIT];
    assign detector_down_enable = detector_q[`DET_DN_EN_BIT];
    assign pump_force_up        = detector_q[`DET_FORCE_UP_BIT];
    assign pump_force_down      = detector_q[`DET_FORCE_DN_BIT];
    assign count_target         = lock_count(lock_cfg_q[`LCFG_COUNT_LSB +: 3]);

    // Register writes; fields are held at their documented widths.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ref_div_q  <= `RST_REF_DIV;
            fb_int_q   <= `RST_FB_INT;
            fb_frac_q  <= `RST_FB_FRAC;
            mode_q     <= `RST_MODE;
            lock_cfg_q <= `RST_LOCK_CFG;
            detector_q <= `RST_DETECTOR;
            pin_ctrl_q <= `RST_PIN_CTRL;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                `REG_REF_DIV:  ref_div_q  <= reg_wdata[13:0];
                `REG_FB_INT:   fb_int_q   <= reg_wdata[18:0];
                `REG_FB_FRAC:  fb_frac_q  <= reg_wdata;
                `REG_MODE:     mode_q     <= reg_wdata;
                `REG_LOCK_CFG: lock_cfg_q <= reg_wdata[11:0];
                `REG_DETECTOR: detector_q <= reg_wdata[10:0];
                `REG_PIN_CTRL: pin_ctrl_q <= reg_wdata[6:0];
                default:       ;
            endcase
        end
    end

    // Read data stand in the cycle after the strobe; unmapped indices read zero.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reg_rdata_q <= 24'h000000;
        end
        else if (reg_read)
        begin
            unique case (reg_addr)
                `REG_REF_DIV:  reg_rdata_q <= {10'h000, ref_div_q};
                `REG_FB_INT:   reg_rdata_q <= {5'h00, fb_int_q};
                `REG_FB_FRAC:  reg_rdata_q <= fb_frac_q;
                `REG_MODE:     reg_rdata_q <= mode_q;
                `REG_LOCK_CFG: reg_rdata_q <= {12'h000, lock_cfg_q};
                `REG_DETECTOR: reg_rdata_q <= {13'h0000, detector_q};
                `REG_PIN_CTRL: reg_rdata_q <= {17'h00000, pin_ctrl_q};
                `REG_STATUS:   reg_rdata_q <= {22'h000000, lock_q, 1'b0};
                default:       reg_rdata_q <= 24'h000000;
            endcase
        end
    end

    // Pin inputs pass three flops; a level is accepted only once the last two agree.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ref_sync_q <= 3'h0;
            vco_sync_q <= 3'h0;
            ref_lvl_q  <= 1'b0;
            vco_lvl_q  <= 1'b0;
        end
        else
        begin
            ref_sync_q <= {ref_sync_q[1:0], ref_in};
            vco_sync_q <= {vco_sync_q[1:0], vco_in};
            if (ref_sync_q[1] == ref_sync_q[2])
                ref_lvl_q <= ref_sync_q[2];
            if (vco_sync_q[1] == vco_sync_q[2])
                vco_lvl_q <= vco_sync_q[2];
        end
    end

    assign ref_tick = (ref_sync_q[1] == ref_sync_q[2]) && ref_sync_q[2] && !ref_lvl_q;
    assign vco_tick = (vco_sync_q[1] == vco_sync_q[2]) && vco_sync_q[2] && !vco_lvl_q;

    // Reference path divider.
    edge_divider #(.WIDTH(14)) ref_divider (
        .clk     (clk),
        .resetn  (resetn),
        .tick    (ref_tick),
        .ratio   (ref_div_q),
        .pulse_q (ref_pulse)
    );

    // First-order accumulator: a carry adds one to the next ratio, averaging int plus frac.
    always_ff @(posedge clk)
    begin
        if (!resetn || !mode_q[`MODE_FRAC_BIT])
        begin
            frac_acc_q   <= 24'h000000;
            frac_carry_q <= 1'b0;
        end
        else if (fb_pulse)
        begin
            {frac_carry_q, frac_acc_q} <= {1'b0, frac_acc_q} + {1'b0, fb_frac_q};
        end
    end

    assign fb_ratio = clamp_ratio({1'b0, fb_int_q} + {19'h00000, frac_carry_q},
                                  mode_q[`MODE_FRAC_BIT]);

    // Feedback path divider.
    edge_divider #(.WIDTH(19)) fb_divider (
        .clk     (clk),
        .resetn  (resetn),
        .tick    (vco_tick),
        .ratio   (fb_ratio),
        .pulse_q (fb_pulse)
    );

    // Phase-frequency detector: both sides set clears both, but an edge on that cycle is kept.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pfd_up_q <= 1'b0;
            pfd_dn_q <= 1'b0;
        end
        else
        begin
            pfd_up_q <= (pfd_up_q && !pfd_dn_q) | ref_pulse;
            pfd_dn_q <= (pfd_dn_q && !pfd_up_q) | fb_pulse;
        end
    end

    // Pump outputs: force wins over comparison, enables mask the detector.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pump_up_q       <= 1'b0;
            pump_down_q     <= 1'b0;
            pump_drive_en_q <= 1'b0;
        end
        else
        begin
            pump_up_q       <= pump_force_up || (pfd_up_q && detector_up_enable);
            pump_down_q     <= pump_force_down || (pfd_dn_q && detector_down_enable);
            pump_drive_en_q <= detector_up_enable || detector_down_enable
                               || pump_force_up || pump_force_down;
        end
    end

    // Window timer wiring; the lock-detect clock is also shown on the test output.
    assign win.div_code    = lock_cfg_q[`LCFG_DIV_LSB +: 3];
    assign win.speed_code  = lock_cfg_q[`LCFG_SPEED_LSB +: 2];
    assign win.start       = ld_enable && win_digital && (ref_pulse || fb_pulse)
                             && (ld_state_q == pll_ctrl_pkg::LD_IDLE);
    assign general_test_output = win.ld_clk;

    ld_window_timer win_timer (
        .clk    (clk),
        .resetn (resetn),
        .win    (win.timer)
    );

    // Fixed window: 10 ns rounded up to two clock cycles (16 ns), counted from the opening edge.
    always_ff @(posedge clk)
    begin
        if (!resetn || ld_state_q != pll_ctrl_pkg::LD_OPEN)
            analog_cnt_q <= 4'h1;
        else
            analog_cnt_q <= analog_cnt_q + 4'h1;
    end

    assign analog_expired = (analog_cnt_q >= 4'(`ANALOG_WIN_CYC));
    assign win_expired    = win_digital ? win.expired : analog_expired;
    assign partner        = first_ref_q ? fb_pulse : ref_pulse;

    // A partner edge on the expiry cycle still counts as inside; order of arrival is ignored.
    assign pair_in  = ld_enable && (((ld_state_q == pll_ctrl_pkg::LD_IDLE) && ref_pulse && fb_pulse)
                      || ((ld_state_q == pll_ctrl_pkg::LD_OPEN) && partner));
    assign pair_out = ld_enable && (ld_state_q == pll_ctrl_pkg::LD_LATE) && partner;

    // Window tracker: opens on the first edge, waits for the partner edge.
    always_ff @(posedge clk)
    begin
        if (!resetn || !ld_enable)
        begin
            ld_state_q  <= pll_ctrl_pkg::LD_IDLE;
            first_ref_q <= 1'b0;
        end
        else
        begin
            unique case (ld_state_q)
                pll_ctrl_pkg::LD_IDLE:
                    if (ref_pulse != fb_pulse)
                    begin
                        ld_state_q  <= pll_ctrl_pkg::LD_OPEN;
                        first_ref_q <= ref_pulse;
                    end
                pll_ctrl_pkg::LD_OPEN:
                    if (partner)
                        ld_state_q <= pll_ctrl_pkg::LD_IDLE;
                    else if (win_expired)
                        ld_state_q <= pll_ctrl_pkg::LD_LATE;
                pll_ctrl_pkg::LD_LATE:
                    if (partner)
                        ld_state_q <= pll_ctrl_pkg::LD_IDLE;
                default:
                    ld_state_q <= pll_ctrl_pkg::LD_IDLE;
            endcase
        end
    end

    // Consecutive in-window counter and lock flag; any late arrival restarts qualification.
    always_ff @(posedge clk)
    begin
        if (!resetn || !ld_enable)
        begin
            win_count_q <= 12'h000;
            lock_q      <= 1'b0;
        end
        else if (pair_out)
        begin
            win_count_q <= 12'h000;
            lock_q      <= 1'b0;
        end
        else if (pair_in && !lock_q)
        begin
            if (win_count_q + 12'h001 >= count_target)
                lock_q <= 1'b1;
            else
                win_count_q <= win_count_q + 12'h001;
        end
    end

    // Shared pin: lock when selected, serial data only while a read borrows it.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            lock_or_serial_out_pin <= 1'b0;
        else if (!pin_ctrl_q[`PIN_SERIAL_BIT] && serial_read_active)
            lock_or_serial_out_pin <= serial_read_data;
        else if (pin_ctrl_q[`PIN_SEL_LSB +: 5] == `PIN_SEL_LOCK
                 || !pin_ctrl_q[`PIN_SERIAL_BIT])
            lock_or_serial_out_pin <= lock_q;
        else
            lock_or_serial_out_pin <= 1'b0;
    end

    a_up_masked : assert property (@(posedge clk) disable iff (!resetn)
        !detector_up_enable && !pump_force_up |=> !pump_up_q || $changed(detector_q))
        else $error("pump went up while up was masked");
    a_down_masked : assert property (@(posedge clk) disable iff (!resetn)
        !detector_down_enable && !pump_force_down |=> !pump_down_q || $changed(detector_q))
        else $error("pump went down while down was masked");
    a_pump_floats : assert property (@(posedge clk) disable iff (!resetn)
        $past(detector_q[10:5] == 6'h00) && $past(resetn) |-> !pump_drive_en_q)
        else $error("pump driven with both enables cleared");
    a_force_holds : assert property (@(posedge clk) disable iff (!resetn)
        pump_force_up && pump_force_down ##1 $stable(detector_q) |-> pump_up_q && pump_down_q)
        else $error("forced pump not held");
    a_disable_clears : assert property (@(posedge clk) disable iff (!resetn)
        !ld_enable |=> !lock_q && win_count_q == 12'h000 && ld_state_q == pll_ctrl_pkg::LD_IDLE)
        else $error("lock detection active while disabled");
    a_late_unlocks : assert property (@(posedge clk) disable iff (!resetn)
        pair_out |=> !lock_q ##1 (!lock_q || $past(pair_in)))
        else $error("late arrival did not clear lock");
    a_lock_qualified : assert property (@(posedge clk) disable iff (!resetn)
        $rose(lock_q) |-> $past(pair_in) && $past(win_count_q) + 12'h001 >= $past(count_target))
        else $error("lock rose before the full count");
    a_status_read : assert property (@(posedge clk) disable iff (!resetn)
        reg_read && reg_addr == `REG_STATUS |=> reg_rdata_q[`STAT_LOCK_BIT] == $past(lock_q))
        else $error("status did not show the lock flag");
    a_pin_shows : assert property (@(posedge clk) disable iff (!resetn)
        pin_ctrl_q == 7'h01 && !serial_read_active ##1 pin_ctrl_q == 7'h01
        |-> lock_or_serial_out_pin == $past(lock_q))
        else $error("pin did not show the lock flag");
    a_analog_len : assert property (@(posedge clk) disable iff (!resetn)
        ld_enable && !win_digital && ld_state_q == pll_ctrl_pkg::LD_IDLE && ref_pulse && !fb_pulse
        ##1 (!fb_pulse && !win_digital && ld_enable) [*2] |=> ld_state_q == pll_ctrl_pkg::LD_LATE)
        else $error("fixed window length wrong");

    c_lock_rise  : cover property (@(posedge clk) disable iff (!resetn) $rose(lock_q));
    c_late_pair  : cover property (@(posedge clk) disable iff (!resetn) pair_out && lock_q);
    c_serial_pin : cover property (@(posedge clk) disable iff (!resetn)
        serial_read_active && lock_q && !pin_ctrl_q[`PIN_SERIAL_BIT]);
endmodule

/* rtl/win_timer_if.sv */
// Signals between the lock tracker and the digital window timer.
`timescale 1ns/1ps
interface win_timer_if;
    logic       start;
    logic [2:0] div_code;
    logic [1:0] speed_code;
    logic       expired;
    logic       ld_clk;

    modport tracker (output start, output div_code, output speed_code,
                     input expired, input ld_clk);
    modport timer   (input start, input div_code, input speed_code,
                     output expired, output ld_clk);
endinterface

/* verif/pll_loop_ctrl_tb_top.sv */
// Self-checking bench for the loop control block, driven through its register port and pins.
`timescale 1ns/1ps
`include "pll_ctrl_cfg.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module pll_loop_ctrl_tb_top;
    logic        clk                = 1'b0;
    logic        resetn             = 1'b0;
    logic [7:0]  reg_addr           = 8'h00;
    logic [23:0] reg_wdata          = 24'h000000;
    logic        reg_write          = 1'b0;
    logic        reg_read           = 1'b0;
    logic        ref_in             = 1'b0;
    logic        vco_in             = 1'b0;
    logic        serial_read_active = 1'b0;
    logic        serial_read_data   = 1'b0;
    logic [23:0] reg_rdata_q;
    logic        pump_up_q;
    logic        pump_down_q;
    logic        pump_drive_en_q;
    logic        lock_or_serial_out_pin;
    logic        general_test_output;
    logic        lock_q;
    logic [23:0] rd_q;
    logic        seen_up;
    logic        ld_clk_seen;
    int          n_fail    = 0;
    int          cmp_count = 0;
    int          cycles    = 0;

    pll_loop_ctrl i_pll_loop_ctrl (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
        .ref_in(ref_in), .vco_in(vco_in), .serial_read_active(serial_read_active),
        .serial_read_data(serial_read_data), .pump_up_q(pump_up_q),
        .pump_down_q(pump_down_q), .pump_drive_en_q(pump_drive_en_q),
        .lock_or_serial_out_pin(lock_or_serial_out_pin),
        .general_test_output(general_test_output), .lock_q(lock_q));

    // Clock at 125 MHz.
    always #4 clk = ~clk;

    // Every driver starts on a rising edge, so back-to-back calls never collide.
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read data is looked at mid-cycle, in the cycle after the strobe; it then holds until the next read.
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata_q;
    endtask

    // Waits, then lands mid-cycle so outputs are settled when looked at.
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // One comparison period: twenty feedback edges, reference edge leading by lag+1 cycles for a nonzero lag.
    task automatic period(input int lag);
        @(posedge clk);
        repeat (19)
        begin
            vco_in <= 1'b1;
            repeat (3) @(posedge clk);
            vco_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
        ref_in <= 1'b1;
        if (lag > 0)
        begin
            gap(lag);
            seen_up = pump_up_q;
            @(posedge clk);
        end
        vco_in <= 1'b1;
        repeat (3) @(posedge clk);
        ref_in <= 1'b0;
        vco_in <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Single place where the run ends.
    task automatic end_of_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hung handshake would stall forever; this ceiling is about three times the planned run.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 25000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(`REG_REF_DIV, rd_q); `CHK("ref_div", 24'h000001, rd_q)
        rd(`REG_DETECTOR, rd_q); `CHK("detector", 24'h000060, rd_q)
        rd(8'h55, rd_q); `CHK("unmapped", 24'h000000, rd_q)
        rd(`REG_STATUS, rd_q); `CHK("status", 24'h000000, rd_q)
        wr(`REG_REF_DIV, 24'hFFFFFF);
        rd(`REG_REF_DIV, rd_q); `CHK("ref_div_max", 24'h003FFF, rd_q)
        wr(`REG_REF_DIV, 24'h000001);
        wr(`REG_FB_INT, 24'hFFFFFF);
        rd(`REG_FB_INT, rd_q); `CHK("fb_int_max", 24'h07FFFF, rd_q)
        wr(`REG_FB_INT, 24'h000014);
        wr(`REG_DETECTOR, 24'h000000);
        gap(3); `CHK("pump_float", 1'b0, pump_drive_en_q)
        wr(`REG_DETECTOR, 24'h000200);
        gap(3); `CHK("force_up", 1'b1, pump_up_q)
        wr(`REG_DETECTOR, 24'h000400);
        gap(3); `CHK("force_dn", 1'b1, pump_down_q)
        `CHK("force_dn_up", 1'b0, pump_up_q)
        wr(`REG_DETECTOR, 24'h000600);
        gap(3); `CHK("force_both_up", 1'b1, pump_up_q)
        `CHK("force_both_dn", 1'b1, pump_down_q)
        wr(`REG_DETECTOR, 24'h000060);
        wr(`REG_LOCK_CFG, 24'h000008);
        repeat (12) period(0);
        gap(4); `CHK("lock_early", 1'b0, lock_q)
        repeat (6) period(0);
        gap(4); `CHK("lock_set", 1'b1, lock_q)
        rd(`REG_STATUS, rd_q); `CHK("status_lock", 24'h000002, rd_q)
        `CHK("pin_lock", 1'b1, lock_or_serial_out_pin)
        @(posedge clk);
        serial_read_active <= 1'b1;
        gap(3); `CHK("pin_serial", 1'b0, lock_or_serial_out_pin)
        @(posedge clk);
        serial_read_active <= 1'b0;
        gap(3); `CHK("pin_back", 1'b1, lock_or_serial_out_pin)
        period(40); `CHK("pump_up_lead", 1'b1, seen_up)
        gap(2); `CHK("lock_late", 1'b0, lock_q)
        wr(`REG_DETECTOR, 24'h000040);
        period(40); `CHK("up_masked", 1'b0, seen_up)
        wr(`REG_DETECTOR, 24'h000060);
        wr(`REG_LOCK_CFG, 24'h000000);
        repeat (18) period(0);
        gap(4); `CHK("lock_disabled", 1'b0, lock_q)
        // Fractional mode lifts a ratio of 16 to 20; a 64-cycle window sits between lag and period.
        wr(`REG_MODE, 24'h000800);
        wr(`REG_FB_INT, 24'h000010);
        wr(`REG_LOCK_CFG, 24'h000E48);
        repeat (18) period(40);
        gap(4); `CHK("lock_digital", 1'b1, lock_q)
        ld_clk_seen = general_test_output;
        gap(4); `CHK("ld_clk", ~ld_clk_seen, general_test_output)
        end_of_test();
    end
endmodule
